// ==== shared/diag_pkg.sv ====
package diag_pkg;

    // message geometry
    localparam int STD_DIAG_BYTES = 6;
    localparam int MSG_BYTES = 15;
    localparam logic [3:0] LAST_BYTE_INDEX = 4'he;

    // fixed octets of the device-related part
    localparam logic [7:0] HEADER_VALUE = 8'h09;
    localparam logic [7:0] SLOT_NUMBER = 8'h00;

    // event type codes in bits 0 to 2 of octet 10
    localparam logic [2:0] EVT_ALL_GONE = 3'h0;
    localparam logic [2:0] EVT_COMING = 3'h1;
    localparam logic [2:0] EVT_GOING = 3'h2;

    // reporting module positions
    localparam int POS_COUNT = 15;
    localparam logic [3:0] POS_MAX = 4'he;

    // module kinds known to the type table
    localparam int KIND_COUNT = 14;
    localparam logic [7:0] TYPE_CODE_UNKNOWN = 8'h00;
    // type codes: values arbitrary, one distinct code per kind
    localparam logic [7:0] TYPE_CODE_TABLE [KIND_COUNT] = '{
        8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16,
        8'h17, 8'h18, 8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h1d
    };

    // summary flag in the first status byte
    localparam int SUMMARY_BIT = 2;
    localparam int SUMMARY_LO = 5;
    localparam int SUMMARY_HI = 7;

    // values after reset
    localparam logic [2:0] CODE_RESET = 3'h0;
    localparam logic [4:0] SEQ_RESET = 5'h00;
    localparam logic [7:0] TYPE_RESET = 8'h00;
    localparam logic [3:0] POS_RESET = 4'h0;
    localparam logic [31:0] STATUS_RESET = 32'hffffffff;
    localparam logic [14:0] ERR_RESET = 15'h0000;
    localparam logic [3:0] IDX_RESET = 4'h0;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [119:0] MSG_RESET = 120'h0;

    typedef enum logic [0:0] {
        SER_IDLE = 1'b0,
        SER_SEND = 1'b1
    } ser_state_type;

    typedef struct packed {
        ser_state_type state;
        logic [3:0] idx;
        logic [119:0] msg;
        logic valid;
        logic [7:0] data;
        logic first;
        logic last;
        logic busy;
    } ser_regs_type;

    typedef struct packed {
        logic [14:0] err;
        logic [2:0] code;
        logic [4:0] seq;
        logic fw_new;
        logic [7:0] type_code;
        logic [3:0] pos;
        logic [31:0] status;
        logic updated;
        logic any_err;
    } build_regs_type;

endpackage

// ==== design/diag_type_lookup.sv ====
`timescale 1ns/1ns
module diag_type_lookup
    import diag_pkg::*;
(
    input wire logic [3:0] kind,
    output logic [7:0] type_code
);

    ////////////////////////////////////////////////////////////////////////
    // fixed table, unknown kinds give a neutral code
    always_comb
    begin
        type_code = TYPE_CODE_UNKNOWN;
        for (int i = 0; i < KIND_COUNT; i++)
        begin
            if (kind == 4'(i))
            begin
                type_code = TYPE_CODE_TABLE[i];
            end
        end
    end

endmodule

// ==== design/diag_byte_streamer.sv ====
`timescale 1ns/1ns
module diag_byte_streamer
    import diag_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic start,
    input wire logic [119:0] msg,
    output logic valid,
    output logic [7:0] data,
    output logic first,
    output logic last,
    output logic busy
);

    ser_regs_type r_q;
    ser_regs_type r_d;

    ////////////////////////////////////////////////////////////////////////
    // snapshot at start so a rebuild during a read cannot tear the message
    always_comb
    begin
        r_d = r_q;
        r_d.valid = 1'b0;
        r_d.first = 1'b0;
        r_d.last = 1'b0;
        unique case (r_q.state)
            SER_IDLE:
            begin
                r_d.busy = start;
                if (start)
                begin
                    r_d.msg = msg;
                    r_d.valid = 1'b1;
                    r_d.first = 1'b1;
                    r_d.data = msg[7:0];
                    r_d.idx = 4'h1;
                    r_d.state = SER_SEND;
                end
            end
            SER_SEND:
            begin
                r_d.busy = 1'b1;
                r_d.valid = 1'b1;
                r_d.data = 8'(r_q.msg >> {r_q.idx, 3'h0});
                r_d.last = (r_q.idx == LAST_BYTE_INDEX);
                r_d.idx = r_q.idx + 4'h1;
                if (r_q.idx == LAST_BYTE_INDEX)
                begin
                    r_d.state = SER_IDLE;
                    r_d.idx = IDX_RESET;
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            r_q <= '{state: SER_IDLE, idx: IDX_RESET, msg: MSG_RESET, valid: 1'b0,
                     data: BYTE_RESET, first: 1'b0, last: 1'b0, busy: 1'b0};
        end
        else
        begin
            r_q <= r_d;
        end
    end

    assign valid = r_q.valid;
    assign data = r_q.data;
    assign first = r_q.first;
    assign last = r_q.last;
    assign busy = r_q.busy;

endmodule

// ==== design/fieldbus_diag_message_builder.sv ====
// Contract
// - message starts with six standard bytes, then the device-related part
// - octet 7 carries the fixed header value
// - octet 8 carries a type code looked up from the module identifier
// - octet 9, the slot number, is always zero
// - octet 10 bits 0-2: all gone, coming or going
// - five-bit sequence count in octet 10 bits 3-7 steps on each code change
// - newer-firmware modules read zero in the sequence field
// - octet 11 holds reporting module position 0 to 14
// - octets 12 to 15 hold four module status bytes
// - status bits read 0 for error and 1 for no error
// - type table gives each module kind one distinct code
// - bit 2 of octet 12 summarises bits 5 to 7 of that byte
`timescale 1ns/1ns
module fieldbus_diag_message_builder
    import diag_pkg::*;
(
    input wire logic CLK,
    input wire logic NRST,
    input wire logic [47:0] STD_DIAG,
    input wire logic EVT_VALID,
    input wire logic [3:0] EVT_KIND,
    input wire logic [3:0] EVT_POSITION,
    input wire logic EVT_ERROR,
    input wire logic EVT_FW_NEW,
    input wire logic [31:0] EVT_STATUS,
    input wire logic DIAG_REQ,
    output logic DIAG_VALID,
    output logic [7:0] DIAG_DATA,
    output logic DIAG_FIRST,
    output logic DIAG_LAST,
    output logic DIAG_BUSY,
    output logic ERROR_ACTIVE,
    output logic MSG_UPDATED
);

    build_regs_type s_q;
    build_regs_type s_d;
    logic [7:0] looked_up_code;
    logic evt_taken;
    logic [14:0] err_next;
    logic [31:0] status_fixed;
    logic [2:0] code_next;
    logic [7:0] octet10;
    logic [119:0] msg;

    ////////////////////////////////////////////////////////////////////////
    // module identifier to type code
    diag_type_lookup diag_type_lookup_i (
        .kind (EVT_KIND),
        .type_code (looked_up_code)
    );

    ////////////////////////////////////////////////////////////////////////
    // positions beyond the last gateway are not reportable and are dropped
    assign evt_taken = EVT_VALID && (EVT_POSITION <= POS_MAX);

    // per-position error flags, one reporting module each
    genvar gi;
    generate
        for (gi = 0; gi < POS_COUNT; gi++)
        begin : g_err
            assign err_next[gi] = (evt_taken && EVT_POSITION == 4'(gi)) ? EVT_ERROR : s_q.err[gi];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // status bytes pass through as reported except the summary bit, 0 = error, 1 = fine
    always_comb
    begin
        status_fixed = EVT_STATUS;
        // summary is fine only when every bit it covers is fine
        status_fixed[SUMMARY_BIT] = &EVT_STATUS[SUMMARY_HI:SUMMARY_LO];
    end

    ////////////////////////////////////////////////////////////////////////
    // classify the transition of the reporting module
    always_comb
    begin
        code_next = s_q.code;
        if (evt_taken)
        begin
            if (EVT_ERROR && !s_q.err[EVT_POSITION])
            begin
                code_next = EVT_COMING;
            end
            else if (!EVT_ERROR && s_q.err[EVT_POSITION])
            begin
                // going only while others still hold an error
                code_next = (|err_next) ? EVT_GOING : EVT_ALL_GONE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state update
    always_comb
    begin
        s_d = s_q;
        s_d.updated = 1'b0;
        if (evt_taken)
        begin
            s_d.err = err_next;
            s_d.code = code_next;
            // five-bit count wraps back to zero on the 32nd change
            if (code_next != s_q.code)
            begin
                s_d.seq = s_q.seq + 5'h01;
            end
            // every taken event refreshes the stored fields
            s_d.fw_new = EVT_FW_NEW;
            s_d.type_code = looked_up_code;
            s_d.pos = EVT_POSITION;
            s_d.status = status_fixed;
            s_d.updated = 1'b1;
        end
        s_d.any_err = |s_d.err;
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            s_q <= '{err: ERR_RESET, code: CODE_RESET, seq: SEQ_RESET, fw_new: 1'b0,
                     type_code: TYPE_RESET, pos: POS_RESET, status: STATUS_RESET,
                     updated: 1'b0, any_err: 1'b0};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // octet 10: sequence field blanked for newer firmware, count itself kept
    assign octet10 = {(s_q.fw_new ? SEQ_RESET : s_q.seq), s_q.code};

    // message image, octet 1 in the lowest byte
    assign msg = {
        s_q.status,          // octets 12-15
        {4'h0, s_q.pos},     // octet 11
        octet10,             // octet 10
        SLOT_NUMBER,
        s_q.type_code,       // octet 8
        HEADER_VALUE,
        STD_DIAG
    };

    ////////////////////////////////////////////////////////////////////////
    // master read: no data exchange path exists beyond this message
    diag_byte_streamer diag_byte_streamer_i (
        .clk (CLK),
        .nrst (NRST),
        .start (DIAG_REQ),
        .msg (msg),
        .valid (DIAG_VALID),
        .data (DIAG_DATA),
        .first (DIAG_FIRST),
        .last (DIAG_LAST),
        .busy (DIAG_BUSY)
    );

    assign ERROR_ACTIVE = s_q.any_err;
    assign MSG_UPDATED = s_q.updated;

endmodule

// ==== verification/diag_master_model.sv ====
`timescale 1ns/1ns
module diag_master_model
(
    input wire logic clk,
    output logic req,
    input wire logic valid,
    input wire logic [7:0] data,
    input wire logic first,
    input wire logic last,
    input wire logic busy
);
    logic [7:0] rx [15];
    int got;
    int first_at;
    int first_hits;
    int busy_hits;
    logic busy_after;
    initial req = 1'b0;
    // one diagnostics read; gap lets the master answer slowly
    // only the diagnostics path is used, no universal block
    task automatic read_msg(input int gap, output bit ok);
        ok = 1'b0;
        got = 0;
        first_at = -1;
        first_hits = 0;
        busy_hits = 0;
        busy_after = 1'b1;
        // the request leaves on a rising edge like every other input
        repeat (gap + 1) @(posedge clk);
        req <= 1'b1;
        @(posedge clk);
        req <= 1'b0;
        // sample on the falling edge, clear of the register updates
        for (int n = 0; n < 40 && !ok; n++)
        begin
            @(negedge clk);
            if (valid && got < 15)
            begin
                if (first)
                begin
                    first_at = got;
                    first_hits++;
                end
                if (busy)
                begin
                    busy_hits++;
                end
                rx[got] = data;
                got++;
                ok = last;
            end
        end
        // one cycle past the last byte the streamer must be idle again
        @(negedge clk);
        busy_after = busy;
    endtask
endmodule

// ==== verification/fieldbus_diag_message_builder_asserts.sv ====
`timescale 1ns/1ns
module diag_msg_checker
    import diag_pkg::*;
(
    input wire logic CLK,
    input wire logic NRST,
    input wire logic EVT_VALID,
    input wire logic [3:0] EVT_POSITION,
    input wire logic EVT_ERROR,
    input wire logic DIAG_REQ,
    input wire logic DIAG_VALID,
    input wire logic [7:0] DIAG_DATA,
    input wire logic DIAG_FIRST,
    input wire logic DIAG_LAST,
    input wire logic DIAG_BUSY,
    input wire logic ERROR_ACTIVE,
    input wire logic MSG_UPDATED
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);
    // read answers and message layout
    read_start_a: assert property (DIAG_REQ && !DIAG_BUSY |=> DIAG_VALID && DIAG_FIRST)
        else $error("read not answered");
    read_len_a: assert property (DIAG_FIRST |-> ##14 DIAG_LAST)
        else $error("last byte misplaced");
    byte_run_a: assert property (DIAG_FIRST |-> DIAG_VALID[*8] ##1 DIAG_VALID[*7])
        else $error("byte run broken");
    busy_span_a: assert property (DIAG_FIRST |-> DIAG_BUSY[*8] ##1 DIAG_BUSY[*7])
        else $error("busy dropped in read");
    header_a: assert property (DIAG_FIRST |-> ##6 DIAG_DATA == HEADER_VALUE)
        else $error("bad header");
    slot_zero_a: assert property (DIAG_FIRST |-> ##8 DIAG_DATA == 8'h00)
        else $error("slot not zero");
    code_range_a: assert property (DIAG_FIRST |-> ##9 DIAG_DATA[2:0] inside {3'h0, 3'h1, 3'h2})
        else $error("bad event code");
    pos_range_a: assert property (DIAG_FIRST |-> ##10 DIAG_DATA <= 8'h0e)
        else $error("position out of range");
    summary_bit_a: assert property (DIAG_FIRST |-> ##11 DIAG_DATA[2] == &DIAG_DATA[7:5])
        else $error("summary bit wrong");
    // events rebuild the message, position 15 is dropped
    rebuild_a: assert property (EVT_VALID && EVT_POSITION != 4'hf |=> MSG_UPDATED)
        else $error("no rebuild");
    no_rebuild_a: assert property (!(EVT_VALID && EVT_POSITION != 4'hf) |=> !MSG_UPDATED)
        else $error("spurious rebuild");
    err_flag_a: assert property (EVT_VALID && EVT_POSITION != 4'hf && EVT_ERROR |=> ERROR_ACTIVE)
        else $error("error flag missing");
    cover property (DIAG_LAST);
    cover property (MSG_UPDATED && ERROR_ACTIVE);
    cover property ($fell(ERROR_ACTIVE));
endmodule
bind fieldbus_diag_message_builder diag_msg_checker diag_msg_checker_i (.CLK, .NRST, .EVT_VALID,
    .EVT_POSITION, .EVT_ERROR, .DIAG_REQ, .DIAG_VALID, .DIAG_DATA, .DIAG_FIRST, .DIAG_LAST,
    .DIAG_BUSY, .ERROR_ACTIVE, .MSG_UPDATED);

// ==== verification/fieldbus_diag_message_builder_tb.sv ====
`timescale 1ns/1ns
module fieldbus_diag_message_builder_tb;
    import diag_pkg::*;
    logic [47:0] STD_DIAG = 48'h665544332211;
    logic CLK = 1'b0, NRST = 1'b0, EVT_VALID = 1'b0, EVT_ERROR = 1'b0, EVT_FW_NEW = 1'b0;
    logic [3:0] EVT_KIND = 4'h0, EVT_POSITION = 4'h0;
    logic [31:0] EVT_STATUS = 32'hffffffff;
    logic DIAG_REQ, DIAG_VALID, DIAG_FIRST, DIAG_LAST, DIAG_BUSY, ERROR_ACTIVE, MSG_UPDATED;
    logic [7:0] DIAG_DATA;
    int num_errors = 0, n_checks = 0;
    fieldbus_diag_message_builder fieldbus_diag_message_builder_i (.CLK, .NRST, .STD_DIAG,
        .EVT_VALID, .EVT_KIND, .EVT_POSITION, .EVT_ERROR, .EVT_FW_NEW, .EVT_STATUS, .DIAG_REQ,
        .DIAG_VALID, .DIAG_DATA, .DIAG_FIRST, .DIAG_LAST, .DIAG_BUSY, .ERROR_ACTIVE, .MSG_UPDATED);
    diag_master_model diag_master_model_i (.clk(CLK), .req(DIAG_REQ), .valid(DIAG_VALID),
        .data(DIAG_DATA), .first(DIAG_FIRST), .last(DIAG_LAST), .busy(DIAG_BUSY));
    initial forever #20 CLK = ~CLK;
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
            num_errors++;
        end
    endtask
    task automatic print_verdict();
        $display("errors %0d checks %0d", num_errors, n_checks);
        if (num_errors == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // one event strobe, then the rebuild pulse is looked at
    task automatic evt(input logic [3:0] k, p, input logic e, f, input logic [31:0] s);
        @(posedge CLK);
        EVT_VALID <= 1'b1;
        EVT_KIND <= k;
        EVT_POSITION <= p;
        EVT_ERROR <= e;
        EVT_FW_NEW <= f;
        EVT_STATUS <= s;
        @(posedge CLK);
        EVT_VALID <= 1'b0;
        @(negedge CLK);
        check({7'h0, MSG_UPDATED}, {7'h0, p != 4'hf});
    endtask
    // full read, every octet compared with the expected layout
    task automatic read_check(input int gap, input logic [7:0] ty, o10, input logic [3:0] p,
        input logic [31:0] s);
        bit ok;
        diag_master_model_i.read_msg(gap, ok);
        check({7'h0, ok}, 8'h01);
        // a lost read is already counted; the verdict comes at the end
        if (!ok)
            return;
        check(diag_master_model_i.got[7:0], 8'h0f);
        check(diag_master_model_i.first_hits[7:0], 8'h01);
        check(diag_master_model_i.first_at[7:0], 8'h00);
        check(diag_master_model_i.busy_hits[7:0], 8'h0f);
        check({7'h0, diag_master_model_i.busy_after}, 8'h00);
        for (int i = 0; i < 6; i++)
            check(diag_master_model_i.rx[i], STD_DIAG[8*i+:8]);
        check(diag_master_model_i.rx[6], 8'h09);
        check(diag_master_model_i.rx[7], ty);
        check(diag_master_model_i.rx[8], 8'h00);
        check(diag_master_model_i.rx[9], o10);
        check(diag_master_model_i.rx[10], {4'h0, p});
        // status passes through, only the summary bit of the first byte is rebuilt
        for (int i = 0; i < 4; i++)
            check(diag_master_model_i.rx[11+i], i == 0 ? {s[7:3], &s[7:5], s[1:0]} : s[8*i+:8]);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic sc_reset_values();
        read_check(0, 8'h00, 8'h00, 4'h0, 32'hffffffff);
    endtask
    // coming, second coming, going with another still in error, all gone
    task automatic sc_coming_going();
        evt(4'h1, 4'h2, 1'b1, 1'b0, 32'h12345678);
        check({7'h0, ERROR_ACTIVE}, 8'h01);
        read_check(0, 8'h11, 8'h09, 4'h2, 32'h12345678);
        evt(4'h2, 4'hd, 1'b1, 1'b1, 32'h0000a0a4);
        read_check(3, 8'h12, 8'h01, 4'hd, 32'h0000a0a4);
        evt(4'h1, 4'h2, 1'b0, 1'b0, 32'hffffff1b);
        read_check(0, 8'h11, 8'h12, 4'h2, 32'hffffff1b);
        evt(4'h2, 4'hd, 1'b0, 1'b0, 32'h00000000);
        check({7'h0, ERROR_ACTIVE}, 8'h00);
        read_check(1, 8'h12, 8'h18, 4'hd, 32'h00000000);
    endtask
    // position 15 leaves the message as it was
    task automatic sc_refused_position();
        evt(4'h5, 4'hf, 1'b1, 1'b0, 32'h11111111);
        check({7'h0, ERROR_ACTIVE}, 8'h00);
        read_check(0, 8'h12, 8'h18, 4'hd, 32'h00000000);
    endtask
    // every kind and every position, plus one kind the table lacks
    task automatic sc_type_table();
        for (int k = 0; k < 15; k++)
        begin
            // standard part changes too, so a stale snapshot shows
            @(posedge CLK);
            STD_DIAG <= {6{4'h5, k[3:0]}};
            evt(k[3:0], k[3:0], 1'b0, 1'b0, 32'hc3a5e100 + k);
            read_check(0, k < 14 ? 8'h10 + k[7:0] : 8'h00, 8'h18, k[3:0], 32'hc3a5e100 + k);
        end
    endtask
    initial
    begin
        repeat (5) @(posedge CLK);
        NRST <= 1'b1;
        sc_reset_values();
        sc_coming_going();
        sc_refused_position();
        sc_type_table();
        print_verdict();
    end
endmodule
